//--- logic/smf_async_tx.sv
`timescale 1ns/1ps
module smf_async_tx
(
  input wire logic clk_link_i,
  input wire logic arst_n_i,
  smf_atr_if.link bus
);
  import smf_pkg::*;

  logic rst_s1_reg, rst_s2_reg, mode_s1_reg, mode_s2_reg;
  logic ce_s1_reg, ce_s2_reg, tog_s1_reg, tog_s2_reg;
  smf_astate_t st_reg, st_next;
  logic [8:0] bitclk_reg, bitclk_next;
  logic [3:0] slot_reg, slot_next;
  logic [2:0] byte_reg, byte_next;
  logic [9:0] frame_reg, frame_next;
  logic [ATR_BITS-1:0] atr_reg, atr_next, work_reg, work_next;
  logic ack_reg, ack_next, low_reg, low_next, rst_d_reg, rst_d_next;

  // start bit, data lsb first, even parity
  function automatic logic [9:0] frame_of(input logic [7:0] d);
    frame_of = {^d, d, 1'b0};
  endfunction

  // link-side synchronisers
  always_ff @(posedge clk_link_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_s1_reg <= PAD_IDLE;
      rst_s2_reg <= PAD_IDLE;
      mode_s1_reg <= 1'b0;
      mode_s2_reg <= 1'b0;
      ce_s1_reg <= 1'b0;
      ce_s2_reg <= 1'b0;
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= bus.rst_pad;
      rst_s2_reg <= rst_s1_reg;
      mode_s1_reg <= bus.mode_pad;
      mode_s2_reg <= mode_s1_reg;
      ce_s1_reg <= bus.ce;
      ce_s2_reg <= ce_s1_reg;
      tog_s1_reg <= bus.load_tog;
      tog_s2_reg <= tog_s1_reg;
    end
  end

  always_comb
  begin
    st_next = st_reg;
    bitclk_next = bitclk_reg;
    slot_next = slot_reg;
    byte_next = byte_reg;
    frame_next = frame_reg;
    atr_next = atr_reg;
    work_next = work_reg;
    ack_next = ack_reg;
    low_next = low_reg;
    rst_d_next = rst_s2_reg;
    unique case (st_reg)
      A_IDLE:
      begin
        low_next = 1'b0;
        // a reset release wins; a pending word copy waits until idle again
        if (rst_s2_reg && !rst_d_reg && !mode_s2_reg)
        begin
          st_next = A_SEND;
          bitclk_next = 9'h000;
          slot_next = 4'h0;
          byte_next = 3'h0;
          work_next = atr_reg >> BYTE_BITS;
          frame_next = frame_of(atr_reg[7:0]);
          low_next = 1'b1;
        end
        else if (tog_s2_reg != ack_reg)
        begin
          atr_next = bus.atr_word;
          ack_next = tog_s2_reg;
        end
      end
      A_SEND:
      begin
        bitclk_next = bitclk_reg + 9'h001;
        if (!rst_s2_reg || mode_s2_reg)
        begin
          st_next = A_IDLE;
          low_next = 1'b0;
        end
        else if (bitclk_reg == ASYNC_BIT_LAST)
        begin
          bitclk_next = 9'h000;
          slot_next = slot_reg + 4'h1;
          if (slot_reg == SLOT_LAST)
          begin
            slot_next = 4'h0;
            if (byte_reg == ATR_LAST)
            begin
              st_next = A_IDLE;
              low_next = 1'b0;
            end
            else
            begin
              byte_next = byte_reg + 3'h1;
              frame_next = frame_of(work_reg[7:0]);
              work_next = work_reg >> BYTE_BITS;
              low_next = 1'b1;
            end
          end
          else
          begin
            frame_next = {1'b1, frame_reg[9:1]};
            low_next = ~frame_reg[1];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_link_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_reg <= A_IDLE;
      bitclk_reg <= 9'h000;
      slot_reg <= 4'h0;
      byte_reg <= 3'h0;
      frame_reg <= FRAME_IDLE;
      atr_reg <= ATR_RESET;
      work_reg <= ATR_RESET;
      ack_reg <= 1'b0;
      low_reg <= 1'b0;
      rst_d_reg <= PAD_IDLE;
    end
    else if (ce_s2_reg)
    begin
      st_reg <= st_next;
      bitclk_reg <= bitclk_next;
      slot_reg <= slot_next;
      byte_reg <= byte_next;
      frame_reg <= frame_next;
      atr_reg <= atr_next;
      work_reg <= work_next;
      ack_reg <= ack_next;
      low_reg <= low_next;
      rst_d_reg <= rst_d_next;
    end
  end

  assign bus.ack_tog = ack_reg;
  assign bus.async_low = low_reg;
endmodule

//--- logic/smf_atr_if.sv
`timescale 1ns/1ps
interface smf_atr_if;
  import smf_pkg::*;
  logic [ATR_BITS-1:0] atr_word;
  logic load_tog;
  logic ack_tog;
  logic async_low;
  logic rst_pad;
  logic mode_pad;
  logic ce;
  modport sys
  (
    output atr_word, load_tog, rst_pad, mode_pad, ce,
    input ack_tog, async_low
  );
  modport link
  (
    input atr_word, load_tog, rst_pad, mode_pad, ce,
    output ack_tog, async_low
  );
endinterface

//--- logic/smf_front_end.sv
`timescale 1ns/1ps
module smf_front_end
(
  input wire logic clk_sys_i,
  input wire logic clk_link_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic rst_pad_i,
  input wire logic mode_sync_i,
  input wire logic [smf_pkg::ADDR_BITS-1:0] dev_sel_i,
  input wire logic atr_load_i,
  input wire logic [smf_pkg::ATR_BITS-1:0] atr_data_i,
  output logic atr_ready_o,
  input wire logic [smf_pkg::BYTE_BITS-1:0] tx_data_i,
  output logic tx_take_o,
  output logic [smf_pkg::BYTE_BITS-1:0] rx_data_o,
  output logic rx_valid_o,
  output logic selected_o
);
  import smf_pkg::*;

  smf_atr_if atr_bus();

  logic scl_s1_reg, scl_s2_reg, scl_d_reg, sda_s1_reg, sda_s2_reg, sda_d_reg;
  logic mode_s1_reg, mode_s2_reg, ack_s1_reg, ack_s2_reg, low_s1_reg, low_s2_reg;
  logic [ADDR_BITS-1:0] dev_s1_reg, dev_s2_reg;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  smf_sstate_t st_reg, st_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next, rx_reg, rx_next, byte_in;
  logic rd_reg, rd_next, phase_reg, phase_next, drv_reg, drv_next;
  logic rxv_reg, rxv_next, take_reg, take_next, oe_reg, oe_next;
  logic tog_reg, tog_next, rdy_reg, rdy_next, sel_reg, sel_next;
  logic [ATR_BITS-1:0] atr_reg, atr_next;

  // two-flop synchronisers for pins and link feedback
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      scl_s1_reg <= PAD_IDLE;
      scl_s2_reg <= PAD_IDLE;
      sda_s1_reg <= PAD_IDLE;
      sda_s2_reg <= PAD_IDLE;
      mode_s1_reg <= 1'b0;
      mode_s2_reg <= 1'b0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      low_s1_reg <= 1'b0;
      low_s2_reg <= 1'b0;
      dev_s1_reg <= 4'h0;
      dev_s2_reg <= 4'h0;
    end
    else if (ce_i)
    begin
      scl_s1_reg <= scl_i;
      scl_s2_reg <= scl_s1_reg;
      sda_s1_reg <= sda_i;
      sda_s2_reg <= sda_s1_reg;
      mode_s1_reg <= mode_sync_i;
      mode_s2_reg <= mode_s1_reg;
      ack_s1_reg <= atr_bus.ack_tog;
      ack_s2_reg <= ack_s1_reg;
      low_s1_reg <= atr_bus.async_low;
      low_s2_reg <= low_s1_reg;
      dev_s1_reg <= dev_sel_i;
      dev_s2_reg <= dev_s1_reg;
    end
  end

  assign scl_rise = scl_s2_reg && !scl_d_reg;
  assign scl_fall = !scl_s2_reg && scl_d_reg;
  assign start_cond = scl_s2_reg && scl_d_reg && sda_d_reg && !sda_s2_reg;
  assign stop_cond = scl_s2_reg && scl_d_reg && !sda_d_reg && sda_s2_reg;
  assign byte_in = {sh_reg[6:0], sda_s2_reg};

  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    rx_next = rx_reg;
    rd_next = rd_reg;
    phase_next = phase_reg;
    drv_next = drv_reg;
    rxv_next = 1'b0;
    take_next = 1'b0;
    tog_next = tog_reg;
    atr_next = atr_reg;
    rdy_next = (ack_s2_reg == tog_reg);
    if (atr_load_i && ack_s2_reg == tog_reg)
    begin
      atr_next = atr_data_i;
      tog_next = ~tog_reg;
      rdy_next = 1'b0;
    end
    if (!mode_s2_reg || stop_cond)
    begin
      st_next = S_IDLE;
      drv_next = 1'b0;
    end
    else if (start_cond)
    begin
      st_next = S_ADDR;
      cnt_next = 3'h0;
      drv_next = 1'b0;
    end
    else
    begin
      unique case (st_reg)
        S_IDLE:
        begin
          drv_next = 1'b0;
        end
        S_ADDR, S_WRITE:
        begin
          if (scl_rise)
          begin
            sh_next = byte_in;
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == BIT_LAST)
            begin
              phase_next = 1'b0;
              st_next = S_ACK;
              if (st_reg == S_WRITE)
              begin
                rx_next = byte_in;
                rxv_next = 1'b1;
              end
              else
              begin
                rd_next = byte_in[0];
                if (byte_in[7:DEV_FIELD_LSB] != dev_s2_reg)
                begin
                  st_next = S_IDLE;
                end
              end
            end
          end
        end
        S_ACK:
        begin
          if (scl_fall)
          begin
            phase_next = 1'b1;
            drv_next = 1'b1;
            if (phase_reg)
            begin
              cnt_next = 3'h0;
              drv_next = 1'b0;
              st_next = S_WRITE;
              if (rd_reg)
              begin
                st_next = S_READ;
                sh_next = tx_data_i;
                drv_next = ~tx_data_i[7];
                cnt_next = 3'h1;
                take_next = 1'b1;
              end
            end
          end
        end
        S_READ:
        begin
          if (scl_fall)
          begin
            sh_next = {sh_reg[6:0], 1'b1};
            drv_next = ~sh_reg[6];
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'h0)
            begin
              drv_next = 1'b0;
              phase_next = 1'b0;
              st_next = S_RACK;
            end
          end
        end
        S_RACK:
        begin
          if (scl_rise)
          begin
            phase_next = !sda_s2_reg;
            if (sda_s2_reg)
            begin
              st_next = S_IDLE;
            end
          end
          else if (scl_fall && phase_reg)
          begin
            st_next = S_READ;
            sh_next = tx_data_i;
            drv_next = ~tx_data_i[7];
            cnt_next = 3'h1;
            take_next = 1'b1;
          end
        end
        default:
        begin
          st_next = S_IDLE;
          drv_next = 1'b0;
        end
      endcase
    end
    oe_next = mode_s2_reg ? drv_next : low_s2_reg;
    sel_next = (st_next != S_IDLE) && (st_next != S_ADDR);
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      scl_d_reg <= PAD_IDLE;
      sda_d_reg <= PAD_IDLE;
      st_reg <= S_IDLE;
      cnt_reg <= 3'h0;
      sh_reg <= 8'h00;
      rx_reg <= 8'h00;
      rd_reg <= 1'b0;
      phase_reg <= 1'b0;
      drv_reg <= 1'b0;
      rxv_reg <= 1'b0;
      take_reg <= 1'b0;
      oe_reg <= 1'b0;
      tog_reg <= 1'b0;
      rdy_reg <= 1'b0;
      sel_reg <= 1'b0;
      atr_reg <= ATR_RESET;
    end
    else if (ce_i)
    begin
      scl_d_reg <= scl_s2_reg;
      sda_d_reg <= sda_s2_reg;
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      rx_reg <= rx_next;
      rd_reg <= rd_next;
      phase_reg <= phase_next;
      drv_reg <= drv_next;
      rxv_reg <= rxv_next;
      take_reg <= take_next;
      oe_reg <= oe_next;
      tog_reg <= tog_next;
      rdy_reg <= rdy_next;
      sel_reg <= sel_next;
      atr_reg <= atr_next;
    end
  end

  // pad only ever pulled low
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sda_o <= 1'b0;
    end
    else
    begin
      sda_o <= 1'b0;
    end
  end

  assign atr_bus.atr_word = atr_reg;
  assign atr_bus.load_tog = tog_reg;
  assign atr_bus.rst_pad = rst_pad_i;
  assign atr_bus.mode_pad = mode_sync_i;
  assign atr_bus.ce = ce_i;

  smf_async_tx u_async_tx
  (
    .clk_link_i(clk_link_i),
    .arst_n_i(arst_n_i),
    .bus(atr_bus.link)
  );

  assign sda_oe_o = oe_reg;
  assign atr_ready_o = rdy_reg;
  assign tx_take_o = take_reg;
  assign rx_data_o = rx_reg;
  assign rx_valid_o = rxv_reg;
  assign selected_o = sel_reg;
endmodule

//--- logic/smf_pkg.sv
package smf_pkg;
  localparam int unsigned ASYNC_BIT_CLKS = 372;
  localparam int unsigned ATR_BITS = 64;
  localparam int unsigned ATR_BYTES = 8;
  localparam int unsigned FRAME_SLOTS = 11;
  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned ADDR_BITS = 4;
  localparam int unsigned DEV_FIELD_LSB = 4;
  localparam logic [8:0] ASYNC_BIT_LAST = 9'(ASYNC_BIT_CLKS - 1);
  localparam logic [3:0] SLOT_LAST = 4'(FRAME_SLOTS - 1);
  localparam logic [2:0] ATR_LAST = 3'(ATR_BYTES - 1);
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [9:0] FRAME_IDLE = 10'h3FF;
  localparam logic [ATR_BITS-1:0] ATR_RESET = 64'h0;
  localparam logic PAD_IDLE = 1'b1;

  typedef enum logic
  {
    A_IDLE = 1'b0,
    A_SEND = 1'b1
  } smf_astate_t;

  typedef enum logic [2:0]
  {
    S_IDLE  = 3'b000,
    S_ADDR  = 3'b001,
    S_ACK   = 3'b011,
    S_WRITE = 3'b010,
    S_READ  = 3'b110,
    S_RACK  = 3'b111
  } smf_sstate_t;
endpackage

//--- verif/smf_front_end_asserts.sv
`timescale 1ns/1ps
module smf_front_end_asserts
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic mode_sync_i,
  input wire logic atr_load_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic atr_ready_o,
  input wire logic tx_take_o,
  input wire logic rx_valid_o,
  input wire logic selected_o
);
  logic [15:0] hold_reg;
  logic [15:0] hold_next;
  logic oe_q_reg;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  // cycles since the pad enable last moved
  always_comb
  begin
    hold_next = (hold_reg == 16'hFFFF) ? hold_reg : hold_reg + 16'h0001;
    if (sda_oe_o != oe_q_reg)
      hold_next = 16'h0000;
  end
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      hold_reg <= 16'hFFFF;
      oe_q_reg <= 1'b0;
    end
    else
    begin
      hold_reg <= hold_next;
      oe_q_reg <= sda_oe_o;
    end
  end
  sequence load_s;
    ce_i && atr_load_i && atr_ready_o;
  endsequence
  sequence async_edge_s;
    !mode_sync_i && $past(!mode_sync_i) && (sda_oe_o != oe_q_reg);
  endsequence
  property load_p;
    load_s |=> !atr_ready_o;
  endproperty
  open_drain_a: assert property (sda_o == 1'b0)
    else $error("data pad driven high");
  async_bit_a: assert property (async_edge_s |-> hold_reg >= 16'h00AA)
    else $error("async bit shorter than one bit period");
  sync_out_edge_a: assert property (
    mode_sync_i && $past(mode_sync_i) && $changed(sda_oe_o) |-> !scl_i)
    else $error("sync output changed while clock high");
  sync_in_edge_a: assert property (rx_valid_o |-> scl_i)
    else $error("byte taken while clock low");
  sync_no_atr_a: assert property (
    mode_sync_i && $past(mode_sync_i, 8) && sda_oe_o |-> selected_o || $past(selected_o, 4))
    else $error("pad driven in sync mode while not addressed");
  rx_addr_a: assert property (rx_valid_o |-> mode_sync_i && selected_o)
    else $error("byte received while not addressed");
  take_addr_a: assert property (tx_take_o |-> selected_o ##1 !tx_take_o)
    else $error("read byte taken while not addressed");
  atr_load_a: assert property (load_p)
    else $error("answer word load not acknowledged");
endmodule

//--- verif/smf_front_end_tb.sv
`timescale 1ns/1ps
module smf_front_end_tb;
  import smf_pkg::*;
  localparam logic [63:0] ATR_WORD = 64'h0123456789ABCDEF;
  localparam logic [3:0] DEV = 4'h5;
  logic clk, clk_link, arst_n, mode_sync, ce, atr_load, host_low, host_scl, rst_pad;
  logic [3:0] dev_sel;
  logic [63:0] atr_data;
  logic [7:0] tx_data, rx_data;
  logic sda_o, sda_oe, atr_ready, tx_take, rx_valid, selected;
  wire sda_w = (sda_oe ? sda_o : 1'b1) & ~host_low;
  wire scl_w = mode_sync ? host_scl : clk_link;
  int n_fail, compares, rx_cnt, take_cnt, oe_cnt;
  smf_front_end u_dut
  (
    .clk_sys_i(clk), .clk_link_i(clk_link), .arst_n_i(arst_n), .ce_i(ce),
    .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .rst_pad_i(rst_pad),
    .mode_sync_i(mode_sync), .dev_sel_i(dev_sel), .atr_load_i(atr_load),
    .atr_data_i(atr_data), .atr_ready_o(atr_ready), .tx_data_i(tx_data),
    .tx_take_o(tx_take), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .selected_o(selected)
  );
  smf_host_model u_host
  (
    .clk_i(clk), .sda_i(sda_w), .scl_o(host_scl), .sda_low_o(host_low), .rst_pad_o(rst_pad)
  );
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    clk_link = 1'b0;
    #7;
    forever #24 clk_link = ~clk_link;
  end
  always @(posedge clk)
  begin
    rx_cnt += (rx_valid === 1'b1);
    take_cnt += (tx_take === 1'b1);
    oe_cnt += (sda_oe === 1'b1);
  end
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic sc_atr_load();
    int i;
    i = 0;
    atr_data <= ATR_WORD;
    atr_load <= 1'b1;
    @(posedge clk);
    atr_load <= 1'b0;
    @(negedge clk);
    chk("ready low", atr_ready, 1'b0);
    while (atr_ready !== 1'b1 && i < 60)
    begin
      @(posedge clk);
      i++;
    end
    chk("ready back", atr_ready, 1'b1);
    if (i >= 60)
      give_verdict();
  endtask
  task automatic sc_atr_send();
    logic [7:0] b;
    logic e;
    int i;
    i = 0;
    u_host.pulse_rst();
    while (sda_oe !== 1'b1 && i < 500)
    begin
      @(posedge clk);
      i++;
    end
    chk("atr start seen", sda_oe, 1'b1);
    if (i >= 500)
      give_verdict();
    repeat (ASYNC_BIT_CLKS / 2) @(posedge clk_link);
    for (int k = 0; k < 88; k++)
    begin
      b = ATR_WORD[8 * (k / 11) +: 8];
      case (k % 11)
        0: e = 1'b0;
        9: e = ^b;
        10: e = 1'b1;
        default: e = b[k % 11 - 1];
      endcase
      chk("atr slot", sda_w, e);
      repeat (ASYNC_BIT_CLKS) @(posedge clk_link);
    end
  endtask
  task automatic sc_sync_no_atr();
    int c0;
    c0 = oe_cnt;
    u_host.pulse_rst();
    repeat (400) @(posedge clk);
    chk("no atr in sync", oe_cnt - c0, 0);
  endtask
  task automatic sc_sync_write();
    logic [8:0] got;
    int c0;
    c0 = rx_cnt;
    u_host.start_cond();
    u_host.byte_io({DEV, 4'h0, 1'b1}, got);
    chk("write addr ack", got[0], 1'b0);
    @(negedge clk);
    chk("selected", selected, 1'b1);
    @(posedge clk);
    u_host.byte_io({8'hA5, 1'b1}, got);
    chk("write data ack", got[0], 1'b0);
    chk("rx data", rx_data, 8'hA5);
    chk("rx count", rx_cnt - c0, 1);
    u_host.stop_cond();
  endtask
  task automatic sc_sync_read();
    logic [8:0] got;
    int c0;
    c0 = take_cnt;
    u_host.start_cond();
    u_host.byte_io({DEV, 4'h1, 1'b1}, got);
    chk("read addr ack", got[0], 1'b0);
    u_host.byte_io({8'hFF, 1'b0}, got);
    chk("read byte 0", got[8:1], 8'h3C);
    u_host.byte_io({8'hFF, 1'b1}, got);
    chk("read byte 1", got[8:1], 8'h3C);
    chk("take count", take_cnt - c0, 2);
    u_host.stop_cond();
  endtask
  task automatic sc_sync_other();
    logic [8:0] got;
    int c0;
    c0 = rx_cnt;
    u_host.start_cond();
    u_host.byte_io({DEV + 4'h1, 4'h0, 1'b1}, got);
    chk("other addr nack", got[0], 1'b1);
    chk("not selected", selected, 1'b0);
    u_host.byte_io({8'h5A, 1'b1}, got);
    chk("no rx", rx_cnt - c0, 0);
    u_host.stop_cond();
  endtask
  initial
  begin
    arst_n = 1'b0;
    mode_sync = 1'b0;
    ce = 1'b1;
    atr_load = 1'b0;
    dev_sel = DEV;
    atr_data = 64'h0;
    tx_data = 8'h3C;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    sc_atr_load();
    sc_atr_send();
    @(posedge clk);
    mode_sync <= 1'b1;
    repeat (10) @(posedge clk);
    sc_sync_no_atr();
    sc_sync_write();
    sc_sync_read();
    sc_sync_other();
    give_verdict();
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
endmodule
bind smf_front_end smf_front_end_asserts u_chk
(
  .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .scl_i(scl_i),
  .mode_sync_i(mode_sync_i), .atr_load_i(atr_load_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .atr_ready_o(atr_ready_o), .tx_take_o(tx_take_o), .rx_valid_o(rx_valid_o),
  .selected_o(selected_o)
);

//--- verif/smf_host_model.sv
`timescale 1ns/1ps
module smf_host_model
(
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o,
  output logic rst_pad_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    rst_pad_o = 1'b1;
  end
  task automatic half();
    repeat (8) @(posedge clk_i);
  endtask
  task automatic pulse_rst();
    rst_pad_o <= 1'b0;
    repeat (20) @(posedge clk_i);
    rst_pad_o <= 1'b1;
  endtask
  task automatic start_cond();
    sda_low_o <= 1'b0;
    half();
    scl_o <= 1'b1;
    half();
    sda_low_o <= 1'b1;
    half();
    scl_o <= 1'b0;
  endtask
  task automatic stop_cond();
    sda_low_o <= 1'b1;
    half();
    scl_o <= 1'b1;
    half();
    sda_low_o <= 1'b0;
    half();
  endtask
  task automatic byte_io(input logic [8:0] out, output logic [8:0] got);
    for (int i = 8; i >= 0; i--)
    begin
      sda_low_o <= ~out[i];
      half();
      scl_o <= 1'b1;
      half();
      got[i] = sda_i;
      scl_o <= 1'b0;
    end
  endtask
endmodule
